//--- hw/cgsl_top.sv
// strap latch, pin reinterpretation and management serial slave
// assumes pins are asynchronous to sys_clk and sda is open drain
`timescale 1ns/10ps
module cgsl_top
	import cgsl_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        power_good_strobe_pd_n,
	input  wire logic        freq_sel_a,
	input  wire logic        freq_sel_b,
	input  wire logic        freq_sel_c,
	input  wire logic        freq_sel_c_high,
	input  wire logic        serial_ref5_enable_strap,
	input  wire logic        debug_port_clock_strap,
	input  wire logic        cpu_clock_stop_n,
	input  wire logic        pci_clock_stop_n,
	input  wire logic        oe_request_n,
	input  wire logic        mgmt_serial_clock,
	input  wire logic        mgmt_serial_data_i,
	output logic             mgmt_serial_data_o,
	output logic             mgmt_serial_data_oe,
	output logic             straps_latched,
	output logic [8:0]       cpu_freq_mhz,
	output logic             power_down,
	output logic             test_mode,
	output logic             test_ref_drive,
	output logic             serial_ref5_mode,
	output logic             third_cpu_mode,
	output logic             cpu_clocks_run,
	output logic             pci_clocks_run,
	output logic             src_clocks_run,
	output logic             pci0_clock_role,
	output logic             src0_req_run,
	output logic             src2_req_run,
	output logic [23:0]      out_enable
);
	import cgsl_pkg::*;

	typedef struct packed {
		cgsl_strap_e strap;
		logic [2:0]  fs;
		logic        src5;
		logic        itp;
		cgsl_bus_e   bus;
		logic [3:0]  bitcnt;
		logic [7:0]  sh;
		logic        rw;
		logic        blk;
		logic        first;
		logic        acked;
		logic [6:0]  idx;
		logic        sda_oe;
		logic        scl_d;
		logic        sda_d;
		logic [8:0]  mhz;
		logic        pd;
		logic        tm;
		logic        tref;
		logic        cpu_run;
		logic        pci_run;
		logic        src_run;
		logic        pci0_role;
		logic        src0_run;
		logic        src2_run;
		logic [23:0] oe;
	} cgsl_top_s;

	cgsl_top_s r_r;
	cgsl_top_s r_nxt;

	logic             s_pg;
	logic             s_fsa;
	logic             s_fsb;
	logic             s_fsc;
	logic             s_fsch;
	logic             s_src5;
	logic             s_itp;
	logic             s_cstp_n;
	logic             s_pstp_n;
	logic             s_req_n;
	logic             s_scl;
	logic             s_sda;
	logic             wr_en;
	logic [6:0]       wr_idx;
	logic [7:0]       wr_data;
	logic [7:0]       rd_data;
	logic [REG_W-1:0] regs;
	logic             scl_rise;
	logic             scl_fall;
	logic             bus_start;
	logic             bus_stop;

	// every pin passes the three-stage filter before use
	cgsl_sync #(
		.W   (12),
		.RST (12'hf80)
	) u_sync (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.din     ({mgmt_serial_data_i, mgmt_serial_clock, oe_request_n,
		            pci_clock_stop_n, cpu_clock_stop_n,
		            debug_port_clock_strap, serial_ref5_enable_strap,
		            freq_sel_c_high, freq_sel_c, freq_sel_b, freq_sel_a,
		            power_good_strobe_pd_n}),
		.dout    ({s_sda, s_scl, s_req_n, s_pstp_n, s_cstp_n, s_itp,
		            s_src5, s_fsch, s_fsc, s_fsb, s_fsa, s_pg})
	);

	cgsl_regfile u_regs (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.wr_en   (wr_en),
		.wr_idx  (wr_idx),
		.wr_data (wr_data),
		.rd_idx  (r_r.idx),
		.rd_data (rd_data),
		.regs    (regs)
	);

	// bus events; start and stop need scl high across two samples
	assign scl_rise  = s_scl & ~r_r.scl_d;
	assign scl_fall  = ~s_scl & r_r.scl_d;
	assign bus_start = s_scl & r_r.scl_d & r_r.sda_d & ~s_sda;
	assign bus_stop  = s_scl & r_r.scl_d & ~r_r.sda_d & s_sda;

	always_comb begin
		logic [7:0] rdb;
		logic [7:0] b_req;
		logic [7:0] b_tst;
		logic [7:0] b_stp;
		logic       pstop;
		logic       cstop;
		rdb     = 8'h00;
		b_req   = cgsl_byte(regs, IDX_REQ);
		b_tst   = cgsl_byte(regs, IDX_TEST);
		b_stp   = cgsl_byte(regs, IDX_STOP);
		pstop   = 1'b0;
		cstop   = 1'b0;
		r_nxt   = r_r;
		wr_en   = 1'b0;
		wr_idx  = r_r.idx;
		wr_data = r_r.sh;

		r_nxt.scl_d = s_scl;
		r_nxt.sda_d = s_sda;

		// strap latch: one capture, then only test mode follows the pins
		case (r_r.strap)
		STRAP_WAIT: begin
			if (s_pg) begin
				r_nxt.fs   = {s_fsc, s_fsb, s_fsa};
				r_nxt.src5 = s_src5;
				r_nxt.itp  = s_itp;
				r_nxt.strap = s_fsch ? STRAP_TEST : STRAP_HELD;
			end
		end
		STRAP_HELD: begin
			r_nxt.strap = STRAP_HELD;
		end
		STRAP_TEST: begin
			r_nxt.fs = {s_fsc, s_fsb, s_fsa};
		end
		default: r_nxt.strap = STRAP_WAIT;
		endcase

		// byte served next: block reads lead with the count
		if (r_r.blk && r_r.first) begin
			rdb = BLK_COUNT;
		end else if (r_r.idx == 7'h00) begin
			rdb = {r_r.fs, rd_data[4:0]};
		end else begin
			rdb = rd_data;
		end

		// management slave; stop and start win over any byte in flight
		if (bus_stop) begin
			r_nxt.bus    = BUS_IDLE;
			r_nxt.sda_oe = 1'b0;
		end else if (bus_start) begin
			r_nxt.bus    = BUS_ADDR;
			r_nxt.bitcnt = 4'h0;
			r_nxt.sda_oe = 1'b0;
		end else begin
			case (r_r.bus)
			BUS_ADDR, BUS_CMD, BUS_CNT, BUS_WR: begin
				if (scl_rise) begin
					r_nxt.sh     = {r_r.sh[6:0], s_sda};
					r_nxt.bitcnt = r_r.bitcnt + 4'h1;
				end else if (scl_fall && r_r.bitcnt == BYTE_LAST) begin
					r_nxt.bitcnt = 4'h0;
					r_nxt.sda_oe = 1'b1;
					case (r_r.bus)
					BUS_ADDR: begin
						if (r_r.sh[7:1] == SLV_ADDR) begin
							r_nxt.rw  = r_r.sh[0];
							r_nxt.bus = BUS_ADDR_AK;
						end else begin
							r_nxt.sda_oe = 1'b0;
							r_nxt.bus    = BUS_IDLE;
						end
					end
					BUS_CMD: begin
						r_nxt.blk   = ~r_r.sh[7];
						r_nxt.idx   = r_r.sh[7] ? r_r.sh[6:0] : 7'h00;
						r_nxt.first = 1'b1;
						r_nxt.bus   = BUS_CMD_AK;
					end
					BUS_CNT: begin
						r_nxt.bus = BUS_CNT_AK;
					end
					default: begin
						wr_en     = 1'b1;
						r_nxt.idx = r_r.idx + 7'h01;
						r_nxt.bus = BUS_WR_AK;
					end
					endcase
				end
			end
			BUS_ADDR_AK, BUS_CMD_AK, BUS_CNT_AK, BUS_WR_AK: begin
				if (scl_fall) begin
					r_nxt.sda_oe = 1'b0;
					case (r_r.bus)
					BUS_ADDR_AK: begin
						if (r_r.rw) begin
							r_nxt.sh     = rdb;
							r_nxt.sda_oe = ~rdb[7];
							r_nxt.bus    = BUS_RD;
							if (r_r.blk && r_r.first) begin
								r_nxt.first = 1'b0;
							end else begin
								r_nxt.idx = r_r.idx + 7'h01;
							end
						end else begin
							r_nxt.bus = BUS_CMD;
						end
					end
					BUS_CMD_AK: begin
						r_nxt.bus = r_r.blk ? BUS_CNT : BUS_WR;
					end
					BUS_CNT_AK: begin
						r_nxt.bus = BUS_WR;
					end
					default: begin
						// single-byte write takes one byte only
						r_nxt.bus = r_r.blk ? BUS_WR : BUS_IDLE;
					end
					endcase
				end
			end
			BUS_RD: begin
				if (scl_fall) begin
					if (r_r.bitcnt[2:0] == RD_LAST) begin
						r_nxt.bitcnt = 4'h0;
						r_nxt.sda_oe = 1'b0;
						r_nxt.bus    = BUS_RD_AK;
					end else begin
						r_nxt.bitcnt = r_r.bitcnt + 4'h1;
						r_nxt.sh     = {r_r.sh[6:0], 1'b0};
						r_nxt.sda_oe = ~r_r.sh[6];
					end
				end
			end
			BUS_RD_AK: begin
				if (scl_rise) begin
					r_nxt.acked = ~s_sda;
				end else if (scl_fall) begin
					if (r_r.acked && r_r.blk) begin
						r_nxt.sh     = rdb;
						r_nxt.sda_oe = ~rdb[7];
						r_nxt.bus    = BUS_RD;
						r_nxt.idx    = r_r.idx + 7'h01;
					end else begin
						r_nxt.bus = BUS_IDLE;
					end
				end
			end
			default: r_nxt.bus = BUS_IDLE;
			endcase
		end

		// stop controls follow the latched straps; pin roles follow the request register
		r_nxt.mhz  = cgsl_cpu_mhz(r_r.fs);
		r_nxt.pd   = (r_r.strap != STRAP_WAIT) & ~s_pg;
		r_nxt.tm   = (r_r.strap == STRAP_TEST) | b_tst[TM_ENTRY];
		r_nxt.tref = (r_r.strap == STRAP_TEST) ? s_fsb : b_tst[TM_SEL];
		// stop inputs exist only when the shared pins are not ref5
		cstop = ~r_r.src5 & ~s_cstp_n;
		pstop = ~r_r.src5 & ~s_pstp_n;
		r_nxt.cpu_run = ~cstop & ~r_nxt.pd;
		r_nxt.pci_run = ~pstop & ~r_nxt.pd;
		r_nxt.src_run = ~r_nxt.pd &
			~(pstop & b_stp[SRC_STP]);
		// request input is active low and gates only its mapped output
		r_nxt.pci0_role = ~b_req[REQ_EN];
		r_nxt.src0_run  = ~(b_req[REQ_EN] & ~b_req[REQ_SEL] & s_req_n);
		r_nxt.src2_run  = ~(b_req[REQ_EN] & b_req[REQ_SEL] & s_req_n);
		r_nxt.oe = {cgsl_byte(regs, IDX_OE_C), cgsl_byte(regs, IDX_OE_B),
			cgsl_byte(regs, IDX_OE_A)};
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			// filtered bus pins idle high, so no false edge follows reset
			r_r       <= '0;
			r_r.scl_d <= 1'b1;
			r_r.sda_d <= 1'b1;
		end else begin
			r_r <= r_nxt;
		end
	end

	// open drain: data is always low, enable pulls the line
	assign mgmt_serial_data_o  = 1'b0;
	assign mgmt_serial_data_oe = r_r.sda_oe;
	assign straps_latched      = r_r.strap[0]; // held and test share bit 0
	assign cpu_freq_mhz        = r_r.mhz;
	assign power_down          = r_r.pd;
	assign test_mode           = r_r.tm;
	assign test_ref_drive      = r_r.tref;
	assign serial_ref5_mode    = r_r.src5;
	assign third_cpu_mode      = r_r.itp;
	assign cpu_clocks_run      = r_r.cpu_run;
	assign pci_clocks_run      = r_r.pci_run;
	assign src_clocks_run      = r_r.src_run;
	assign pci0_clock_role     = r_r.pci0_role;
	assign src0_req_run        = r_r.src0_run;
	assign src2_req_run        = r_r.src2_run;
	assign out_enable          = r_r.oe;
endmodule

//--- hw/cgsl_pkg.sv
// constants, types and helpers of the strap latch and management slave
// assumes one 125 MHz system clock; controls come on plain ports and over the management serial slave
package cgsl_pkg;

	// management serial slave address, upper seven bits of the byte
	localparam logic [6:0] SLV_ADDR  = 7'h69;
	localparam logic [3:0] BYTE_LAST = 4'h8;
	localparam logic [2:0] RD_LAST   = 3'h7;

	// register file geometry
	localparam int         NREG      = 10;
	localparam int         REG_W     = NREG * 8;
	localparam logic [7:0] BLK_COUNT = 8'h0a;
	localparam logic [6:0] IDX_LIMIT = 7'h0a;

	// register indices
	localparam int         IDX_CTRL0 = 0;
	localparam int         IDX_OE_A  = 2;
	localparam int         IDX_OE_B  = 3;
	localparam int         IDX_OE_C  = 4;
	localparam int         IDX_REQ   = 5;
	localparam int         IDX_STOP  = 6;
	localparam int         IDX_ID    = 7;
	localparam int         IDX_TEST  = 9;
	localparam logic [6:0] IDX_ID_7  = 7'h07;

	// field positions
	localparam int         REQ_EN    = 7;
	localparam int         REQ_SEL   = 6;
	localparam int         SRC_STP   = 0;
	localparam int         TM_SEL    = 4;
	localparam int         TM_ENTRY  = 3;

	// identification byte; value is arbitrary
	localparam logic [7:0] ID_BYTE   = 8'h5a;

	// power-up contents, byte 0 in the low lane
	localparam logic [REG_W-1:0] REG_DEFAULT = {
		8'h25, 8'h00, ID_BYTE, 8'h00, 8'h00,
		8'hff, 8'hff, 8'hff, 8'h03, 8'h01};

	// cpu output frequencies in MHz
	localparam logic [8:0] MHZ_100 = 9'h064;
	localparam logic [8:0] MHZ_133 = 9'h085;
	localparam logic [8:0] MHZ_166 = 9'h0a6;
	localparam logic [8:0] MHZ_200 = 9'h0c8;
	localparam logic [8:0] MHZ_266 = 9'h10a;
	localparam logic [8:0] MHZ_333 = 9'h14d;
	localparam logic [8:0] MHZ_400 = 9'h190;

	typedef enum logic [3:0] {
		BUS_IDLE    = 4'h0,
		BUS_ADDR    = 4'h1,
		BUS_ADDR_AK = 4'h3,
		BUS_CMD     = 4'h2,
		BUS_CMD_AK  = 4'h6,
		BUS_CNT     = 4'h7,
		BUS_CNT_AK  = 4'h5,
		BUS_WR      = 4'h4,
		BUS_WR_AK   = 4'hc,
		BUS_RD      = 4'hd,
		BUS_RD_AK   = 4'hf
	} cgsl_bus_e;

	typedef enum logic [1:0] {
		STRAP_WAIT = 2'h0,
		STRAP_HELD = 2'h1,
		STRAP_TEST = 2'h3
	} cgsl_strap_e;

	// pick one byte out of the flat register image
	function automatic logic [7:0] cgsl_byte(input logic [REG_W-1:0] v,
		input int k);
		return v[k*8 +: 8];
	endfunction

	// {c,b,a} select code to cpu frequency
	function automatic logic [8:0] cgsl_cpu_mhz(input logic [2:0] fs);
		logic [8:0] m;
		m = MHZ_200;
		case (fs)
		3'h0: m = MHZ_266;
		3'h1: m = MHZ_133;
		3'h2: m = MHZ_200;
		3'h3: m = MHZ_166;
		3'h4: m = MHZ_333;
		3'h5: m = MHZ_100;
		3'h6: m = MHZ_400;
		default: m = MHZ_200;
		endcase
		return m;
	endfunction

endpackage

//--- hw/cgsl_sync.sv
// three-stage input synchroniser with agreement filter
// assumes asynchronous pins; output moves once stages two and three agree
`timescale 1ns/10ps
module cgsl_sync #(
	parameter int            W   = 1,
	parameter logic [W-1:0]  RST = '0
) (
	input  wire logic         sys_clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} cgsl_sync_s;

	cgsl_sync_s r_r;
	cgsl_sync_s r_nxt;

	// only stage two and three feed the filter, never stage one
	always_comb begin
		r_nxt    = r_r;
		r_nxt.s1 = din;
		r_nxt.s2 = r_r.s1;
		r_nxt.s3 = r_r.s2;
		r_nxt.q  = (r_r.s2 & r_r.s3) | (r_r.q & (r_r.s2 ^ r_r.s3));
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			r_r <= {RST, RST, RST, RST};
		end else begin
			r_r <= r_nxt;
		end
	end

	assign dout = r_r.q;
endmodule

//--- hw/cgsl_regfile.sv
// byte register file behind the management serial slave
// assumes writes come from the slave engine, one byte per cycle at most
`timescale 1ns/10ps
module cgsl_regfile
	import cgsl_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	input  wire logic              wr_en,
	input  wire logic [6:0]        wr_idx,
	input  wire logic [7:0]        wr_data,
	input  wire logic [6:0]        rd_idx,
	output logic      [7:0]        rd_data,
	output logic      [REG_W-1:0]  regs
);
	typedef struct packed {
		logic [NREG-1:0][7:0] mem;
	} cgsl_rf_s;

	cgsl_rf_s r_r;
	cgsl_rf_s r_nxt;

	// identification byte is read only; out of range writes are dropped
	always_comb begin
		r_nxt = r_r;
		if (wr_en && wr_idx < IDX_LIMIT && wr_idx != IDX_ID_7) begin
			r_nxt.mem[wr_idx[3:0]] = wr_data;
		end
	end

	// only the global reset restores defaults; power-down keeps contents
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			r_r <= REG_DEFAULT;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign rd_data = (rd_idx < IDX_LIMIT) ? r_r.mem[rd_idx[3:0]] : 8'h00;
	assign regs    = r_r;
endmodule

//--- verification/cgsl_checker.sv
// assertions on the strap latch and serial slave pins of cgsl_top
// assumes one clock domain; sees only the top module's ports
`timescale 1ns/10ps
module cgsl_checker (
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic        power_good_strobe_pd_n,
	input wire logic        cpu_clock_stop_n,
	input wire logic        mgmt_serial_clock,
	input wire logic        mgmt_serial_data_o,
	input wire logic        mgmt_serial_data_oe,
	input wire logic        straps_latched,
	input wire logic [8:0]  cpu_freq_mhz,
	input wire logic        power_down,
	input wire logic        test_mode,
	input wire logic        serial_ref5_mode,
	input wire logic        cpu_clocks_run,
	input wire logic        pci_clocks_run,
	input wire logic        pci0_clock_role,
	input wire logic [23:0] out_enable
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	// open drain: the slave may only ever pull the line low
	a_sda_drain: assert property (mgmt_serial_data_o == 1'b0)
		else $error("sda output not low");
	a_latch_once: assert property (straps_latched |=> straps_latched)
		else $error("strap latch dropped");
	a_freq_frozen: assert property (
		(straps_latched && !test_mode)[*2] |=> $stable(cpu_freq_mhz))
		else $error("cpu frequency moved after latch");
	a_pd_needs_latch: assert property (power_down |-> straps_latched)
		else $error("power down before strap latch");
	// pin filter and register give up to five clocks of lag
	a_pd_from_pin: assert property (
		(straps_latched && !power_good_strobe_pd_n)[*7] |-> power_down)
		else $error("power down request missed");
	// stop pin is honoured only when the shared pins are not ref5
	a_cpu_stop: assert property (
		(straps_latched && !serial_ref5_mode && !cpu_clock_stop_n)[*7]
		|-> !cpu_clocks_run)
		else $error("cpu stop request ignored");
	a_pd_stops: assert property (
		power_down[*2] |-> !cpu_clocks_run && !pci_clocks_run)
		else $error("clocks run in power down");
	a_ref5_runs: assert property (
		(serial_ref5_mode && straps_latched && !power_down
		&& !test_mode)[*2] |-> cpu_clocks_run && pci_clocks_run)
		else $error("stop honoured while pins are clocks");
	// sda may only move while scl is low, else it would fake start or stop
	a_sda_scl_low: assert property (
		$changed(mgmt_serial_data_oe) |-> !mgmt_serial_clock)
		else $error("sda drive changed while scl high");
	a_oe_default: assert property (
		$rose(nrst) |=> out_enable == 24'hffffff)
		else $error("output enables not at defaults");
	a_pci0_clock: assert property ($rose(nrst) |=> pci0_clock_role)
		else $error("pci0 pin not a clock after reset");

	c_latch: cover property ($rose(straps_latched));
	c_pd: cover property ($rose(power_down));
	c_ack: cover property ($rose(mgmt_serial_data_oe));
	c_test: cover property ($rose(test_mode));
endmodule

bind cgsl_top cgsl_checker u_chk (
	.sys_clk(sys_clk), .nrst(nrst),
	.power_good_strobe_pd_n(power_good_strobe_pd_n),
	.cpu_clock_stop_n(cpu_clock_stop_n),
	.mgmt_serial_clock(mgmt_serial_clock),
	.mgmt_serial_data_o(mgmt_serial_data_o),
	.mgmt_serial_data_oe(mgmt_serial_data_oe),
	.straps_latched(straps_latched), .cpu_freq_mhz(cpu_freq_mhz),
	.power_down(power_down), .test_mode(test_mode),
	.serial_ref5_mode(serial_ref5_mode),
	.cpu_clocks_run(cpu_clocks_run), .pci_clocks_run(pci_clocks_run),
	.pci0_clock_role(pci0_clock_role), .out_enable(out_enable)
);

//--- verification/cgsl_host.sv
// management serial host model: drives scl, pulls sda low
// assumes a pull-up on sda; scl stands high between frames
`timescale 1ns/10ps
module cgsl_host (
	input  wire logic sys_clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_pull
);
	// bus idle at time zero
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic hw(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// start or repeated start; 3-clock gaps keep sda clear of scl edges
	task automatic st();
		sda_pull = 1'b0;
		hw(3);
		scl = 1'b1;
		hw(10);
		sda_pull = 1'b1;
		hw(10);
		scl = 1'b0;
		hw(3);
	endtask

	task automatic sp();
		sda_pull = 1'b1;
		hw(3);
		scl = 1'b1;
		hw(10);
		sda_pull = 1'b0;
		hw(10);
	endtask

	// one bit; 10-clock phases beat the slave filter's 2-clock minimum
	task automatic bt(input logic b, output logic s);
		sda_pull = !b;
		hw(10);
		scl = 1'b1;
		hw(5);
		s = sda;
		hw(5);
		scl = 1'b0;
		hw(3);
	endtask

	// byte msb first, then the ninth slot with the host's level nb
	task automatic xb(input logic [7:0] d, input logic nb,
		output logic [7:0] r, output logic s9);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bt(d[i], b);
			r[i] = b;
		end
		bt(nb, s9);
	endtask
endmodule

//--- verification/clock_gen_strap_latch_and_smbus_slave_bench.sv
// self-checking bench for cgsl_top with a host model on the serial pins
// assumes the checker is bound in and inputs move at the falling edge
`timescale 1ns/10ps
module clock_gen_strap_latch_and_smbus_slave_bench
	import cgsl_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        pg = 1'b0;
	logic [2:0]  fs = 3'h0;
	logic        fch, r5s, dbs, cstp_n, pstp_n, oereq_n;
	logic        scl, hpull, sda_o, sda_oe, latched, pd, tm, tref;
	logic        r5m, c3m, crun, prun, role, srun, s0r, s2r;
	logic [8:0]  freq;
	logic [23:0] oen;
	wire         sda;
	int          bad_count = 0;
	int          tests_run = 0;
	logic [31:0] seed = 32'h4e427876;

	// pull-up wins unless someone pulls low
	assign sda = !(hpull || sda_oe);

	always #4 sys_clk = ~sys_clk;

	cgsl_top dut (
		.sys_clk(sys_clk), .nrst(nrst), .power_good_strobe_pd_n(pg),
		.freq_sel_a(fs[0]), .freq_sel_b(fs[1]), .freq_sel_c(fs[2]),
		.freq_sel_c_high(fch), .serial_ref5_enable_strap(r5s),
		.debug_port_clock_strap(dbs), .cpu_clock_stop_n(cstp_n),
		.pci_clock_stop_n(pstp_n), .oe_request_n(oereq_n),
		.mgmt_serial_clock(scl), .mgmt_serial_data_i(sda),
		.mgmt_serial_data_o(sda_o), .mgmt_serial_data_oe(sda_oe),
		.straps_latched(latched), .cpu_freq_mhz(freq),
		.power_down(pd), .test_mode(tm), .test_ref_drive(tref),
		.serial_ref5_mode(r5m), .third_cpu_mode(c3m),
		.cpu_clocks_run(crun), .pci_clocks_run(prun),
		.src_clocks_run(srun), .pci0_clock_role(role),
		.src0_req_run(s0r), .src2_req_run(s2r), .out_enable(oen)
	);

	cgsl_host u_h (.sys_clk(sys_clk), .sda(sda), .scl(scl),
		.sda_pull(hpull));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// expected cpu frequency for a {c,b,a} code
	function automatic logic [8:0] ef(input logic [2:0] c);
		case (c)
		3'h0: ef = MHZ_266;
		3'h1: ef = MHZ_133;
		3'h3: ef = MHZ_166;
		3'h4: ef = MHZ_333;
		3'h5: ef = MHZ_100;
		3'h6: ef = MHZ_400;
		default: ef = MHZ_200;
		endcase
	endfunction

	task automatic results();
		if (bad_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string n, input logic [23:0] e,
		input logic [23:0] s);
		tests_run++;
		if (s !== e) begin
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
			bad_count++;
		end
	endtask

	task automatic hw(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// reset, set straps well ahead of the strobe, then raise it
	task automatic boot(input logic [2:0] f, input logic h,
		input logic [1:0] s);
		pg = 1'b0;
		nrst = 1'b0;
		fs = f;
		fch = h;
		{dbs, r5s} = s;
		hw(8);
		nrst = 1'b1;
		hw(8);
		pg = 1'b1;
		for (int i = 0; i < 30 && latched !== 1'b1; i++) hw(1);
		hw(2);
	endtask

	// a byte other than ff is a write and must be acknowledged
	task automatic tx(input logic [7:0] d, input logic nb,
		output logic [7:0] r);
		logic s;
		u_h.xb(d, nb, r, s);
		if (d != 8'hff) chk("ack", 1'b0, s);
	endtask

	task automatic wr1(input logic [7:0] c, input logic [7:0] v);
		logic [7:0] r;
		u_h.st();
		tx(8'hd2, 1'b1, r);
		tx(c, 1'b1, r);
		tx(v, 1'b1, r);
		u_h.sp();
	endtask

	task automatic rd1(input logic [7:0] c, output logic [7:0] r);
		u_h.st();
		tx(8'hd2, 1'b1, r);
		tx(c, 1'b1, r);
		u_h.st();
		tx(8'hd3, 1'b1, r);
		tx(8'hff, 1'b1, r);
		u_h.sp();
	endtask

	// watchdog well beyond the expected eleven thousand clocks
	initial begin
		repeat (40000) @(posedge sys_clk);
		bad_count++;
		results();
	end

	initial begin
		logic [31:0] v;
		logic [7:0]  r;
		logic        s;
		{fch, r5s, dbs, cstp_n, pstp_n, oereq_n} = 6'h07;
		// every select code; later pin and strobe moves must not relatch
		for (int k = 0; k < 8; k++) begin
			v = rnd();
			boot(k[2:0], 1'b0, v[1:0]);
			chk("freq", ef(k[2:0]), freq);
			chk("ref5", v[0], r5m);
			chk("dbg", v[1], c3m);
			chk("oe", 24'hffffff, oen);
			chk("role", 1'b1, role);
			{fs, r5s, dbs} = ~{fs, r5s, dbs};
			pg = 1'b0;
			hw(10);
			chk("pd", 1'b1, pd);
			chk("pdrun", 1'b0, crun);
			pg = 1'b1;
			hw(10);
			chk("hold", ef(k[2:0]), freq);
			chk("hold5", v[0], r5m);
			chk("nopd", 1'b0, pd);
			{cstp_n, pstp_n} = 2'b00;
			hw(10);
			chk("cstop", v[0], crun);
			chk("pstop", v[0], prun);
			{cstp_n, pstp_n} = 2'b11;
		end
		// test mode entry; select-b picks the output behaviour live
		boot(3'h2, 1'b1, 2'b01);
		chk("tm", 1'b1, tm);
		chk("tref", 1'b1, tref);
		fs = 3'h0;
		hw(10);
		chk("tri", 1'b0, tref);
		chk("live", MHZ_266, freq);
		// single-byte access, including the read-only id byte
		v = rnd();
		boot(v[2:0], 1'b0, v[4:3]);
		wr1(8'h82, v[15:8]);
		hw(2);
		chk("oe0", v[15:8], oen[7:0]);
		rd1(8'h82, r);
		chk("rd", v[15:8], r);
		wr1(8'h87, ~ID_BYTE);
		rd1(8'h87, r);
		chk("id", ID_BYTE, r);
		// register test entry, reference stop gating, request mapping
		wr1(8'h89, 8'h18);
		hw(2);
		chk("rtm", 2'b11, {tm, tref});
		wr1(8'h89, 8'h25);
		wr1(8'h86, 8'h01);
		pstp_n = 1'b0;
		hw(10);
		chk("srcstp", {2{v[3]}}, {srun, prun});
		pstp_n = 1'b1;
		wr1(8'h85, 8'h80);
		hw(8);
		chk("req0", 3'b001, {role, s0r, s2r});
		oereq_n = 1'b0;
		hw(10);
		chk("req0on", 3'b011, {role, s0r, s2r});
		oereq_n = 1'b1;
		wr1(8'h85, 8'hc0);
		hw(8);
		chk("req2", 3'b010, {role, s0r, s2r});
		// block write of three bytes, stopped before the register end
		u_h.st();
		tx(8'hd2, 1'b1, r);
		tx(8'h00, 1'b1, r);
		tx(8'h03, 1'b1, r);
		tx(8'h01, 1'b1, r);
		tx(v[23:16], 1'b1, r);
		tx(v[31:24], 1'b1, r);
		u_h.sp();
		chk("blk", v[31:24], oen[7:0]);
		// block read: count first, then bytes upward from index zero
		u_h.st();
		tx(8'hd2, 1'b1, r);
		tx(8'h00, 1'b1, r);
		u_h.st();
		tx(8'hd3, 1'b1, r);
		tx(8'hff, 1'b0, r);
		chk("count", BLK_COUNT, r);
		tx(8'hff, 1'b0, r);
		chk("b0", {v[2:0], 5'h01}, r);
		tx(8'hff, 1'b0, r);
		chk("b1", v[23:16], r);
		tx(8'hff, 1'b1, r);
		u_h.sp();
		chk("b2", v[31:24], r);
		// a foreign address gets no acknowledge
		u_h.st();
		u_h.xb(8'hd4, 1'b1, r, s);
		u_h.sp();
		chk("nack", 1'b1, s);
		// contents survive a power-down request
		pg = 1'b0;
		hw(10);
		rd1(8'h82, r);
		chk("keep", v[31:24], r);
		pg = 1'b1;
		hw(10);
		results();
	end
endmodule
